// ==== logic/ucr_pkg.sv ====
/*
  constants for one serial channel: register offsets, field positions,
  reset values, identification codes and oversampling figure.
  assumes an 8-bit host bus with a 3-bit address, synchronous to clk_sys.
*/
// Summary of operation
// RULE1: ident bit 0 reads 0 while an enabled interrupt pends, else 1.
// RULE2: ident bits 2..1 encode the highest priority pending interrupt.
// RULE3: ident bits 7..3 always read zero.
// RULE4: enable bit 0 gates received data, bit 1 gates holding empty.
// RULE5: enable bit 2 gates line status, bit 3 gates modem status.
// RULE6: enable bits 7..4 always held at zero.
// RULE7: interrupt output is active high, driven only by enabled sources.
// RULE8: all enables clear gives no interrupt; status flags still set.
// RULE9: idle transmitter shows holding empty and all empty high.
// RULE10: writing the holding register clears holding empty.
// RULE11: holding moves to shifter at start bit; holding empty rises then.
// RULE12: all empty stays low while a word shifts out.
// RULE13: second character waits in holding until shifter finishes.
// RULE14: all empty rises after last word; holding empty by one transfer.
// RULE15: host writes holding register only while holding empty is high.
// RULE16: data bit 0 is first out on transmit and first in on receive.
// RULE17: priority line status, received data, holding empty, modem status.
// RULE18: holding empty interrupt cleared by ident read or holding write.
// RULE19: low and high divisor latches form one 16-bit divisor.
// RULE20: shifter sends start, data lsb first, optional parity, stops.
package ucr_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_IIR = 3'h2;
  localparam logic [2:0] OFS_LCR = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int LCR_SEL = 7;
  localparam int LCR_BRK = 6;
  localparam int LCR_STICK = 5;
  localparam int LCR_EVEN = 4;
  localparam int LCR_PAR = 3;
  localparam int LCR_STOP = 2;
  // ------------------------------------------------------------
  // identification codes and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] ID_NONE = 3'h1;
  localparam logic [2:0] ID_LINE = 3'h6;
  localparam logic [2:0] ID_RX = 3'h4;
  localparam logic [2:0] ID_TX = 3'h2;
  localparam logic [2:0] ID_MODEM = 3'h0;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0001;
  localparam logic [3:0] OVERSAMPLE = 4'hF;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucr_tx_t;
endpackage

// ==== logic/ucr_baud.sv ====
/*
  baud divider: one-cycle 16x enable from the 16-bit divisor.
  assumes reload pulses whenever a divisor latch is written.
*/
`timescale 1ns/10ps
module ucr_baud
  import ucr_pkg::*;
#(
  parameter int DW = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [DW-1:0] divisor,
  input wire logic reload,
  output logic tick16
);
  logic [DW-1:0] cnt_q;

  // ------------------------------------------------------------
  // count down, reload at once on a latch write
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= DW'(RST_DIV);
      tick16 <= 1'b0;
    end else if (reload || cnt_q <= DW'(1)) begin
      cnt_q <= divisor;
      tick16 <= !reload && divisor != '0;
    end else begin
      cnt_q <= cnt_q - DW'(1);
      tick16 <= 1'b0;
    end
  end
endmodule // ucr_baud

// ==== logic/ucr_tx.sv ====
/*
  transmit shifter: start bit, data lsb first, parity, stop bits.
  assumes tick16 is a one-cycle enable at sixteen times the bit rate.
*/
`timescale 1ns/10ps
module ucr_tx
  import ucr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tick16,
  input wire logic hold_full,
  input wire logic [7:0] hold_data,
  input wire logic [7:0] line_control,
  output logic take,
  output logic busy,
  output logic serial_out
);
  ucr_tx_t state_q;
  logic [7:0] shift_q;
  logic [3:0] sub_q;
  logic [2:0] bit_q;
  logic par_q;
  logic stop2_q;
  logic bit_end;
  logic [2:0] last_bit;

  assign bit_end = tick16 && sub_q == OVERSAMPLE;
  assign last_bit = 3'(line_control[1:0]) + 3'h4;
  assign take = state_q == TX_IDLE && hold_full;
  assign busy = state_q != TX_IDLE;

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= TX_IDLE;
      shift_q <= RST_REG;
      sub_q <= '0;
      bit_q <= '0;
      par_q <= 1'b0;
      stop2_q <= 1'b0;
    end else begin
      if (tick16) sub_q <= sub_q + 4'h1;
      unique case (state_q)
        TX_IDLE: if (take) begin // see RULE11
          shift_q <= hold_data;
          par_q <= 1'b0;
          sub_q <= '0;
          state_q <= TX_START;
        end
        TX_START: if (bit_end) begin
          bit_q <= '0;
          state_q <= TX_DATA;
        end
        TX_DATA: if (bit_end) begin
          par_q <= par_q ^ shift_q[0];
          shift_q <= {1'b0, shift_q[7:1]}; // see RULE16
          bit_q <= bit_q + 3'h1;
          if (bit_q == last_bit) begin
            stop2_q <= line_control[LCR_STOP];
            state_q <= line_control[LCR_PAR] ? TX_PAR : TX_STOP;
          end
        end
        TX_PAR: if (bit_end) state_q <= TX_STOP;
        TX_STOP: if (bit_end) begin
          if (stop2_q) stop2_q <= 1'b0;
          else state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // serial line level
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      serial_out <= 1'b1;
    end else if (line_control[LCR_BRK]) begin
      serial_out <= 1'b0;
    end else begin
      unique case (state_q) // see RULE20
        TX_IDLE: serial_out <= 1'b1;
        TX_START: serial_out <= 1'b0;
        TX_DATA: serial_out <= shift_q[0];
        TX_PAR: serial_out <= line_control[LCR_STICK] ? !line_control[LCR_EVEN]
                                                      : par_q ^ !line_control[LCR_EVEN];
        TX_STOP: serial_out <= 1'b1;
      endcase
    end
  end
endmodule // ucr_tx

// ==== logic/ucr_channel.sv ====
/*
  one serial channel: host register file, interrupt identification,
  transmit holding path and modem status deltas.
  assumes the host strobes and the receiver event pulses are synchronous
  to clk_sys; the modem lines come from pins and are synchronised here.
*/
`timescale 1ns/10ps
module ucr_channel
  import ucr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic rx_load,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_err,
  input wire logic rx_framing_err,
  input wire logic rx_break,
  input wire logic [3:0] modem_in,
  output logic [4:0] modem_ctrl,
  output logic [15:0] divisor,
  output logic tick16,
  output logic serial_out,
  output logic irq_out
);
  logic [7:0] rx_buffer_q;
  logic [7:0] tx_holding_q;
  logic hold_full_q;
  logic [7:0] divisor_low_q;
  logic [7:0] divisor_high_q;
  logic [3:0] irq_enable_q;
  logic [7:0] line_control_q;
  logic [4:0] modem_control_q;
  logic [7:0] scratch_q;
  logic rx_ready_q;
  logic overrun_q;
  logic parity_err_q;
  logic framing_err_q;
  logic break_seen_q;
  logic tx_irq_q;
  logic tx_holding_empty_prev_q;
  logic [3:0] msync1_q;
  logic [3:0] msync2_q;
  logic [3:0] mprev_q;
  logic [3:0] mdelta_q;
  logic [3:0] mset;
  logic divisor_select;
  logic wr_data;
  logic wr_div;
  logic div_load_q;
  logic rd_buf;
  logic rd_iir;
  logic rd_lsr;
  logic rd_msr;
  logic tx_take;
  logic tx_busy;
  logic tx_holding_empty;
  logic tx_all_empty;
  logic src_line;
  logic src_rx;
  logic src_tx;
  logic src_modem;
  logic [2:0] ident;
  logic [7:0] irq_ident;
  logic [7:0] line_status;
  logic [7:0] modem_status;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign divisor_select = line_control_q[LCR_SEL];
  assign wr_data = wr_en && addr == OFS_DATA && !divisor_select;
  assign wr_div = wr_en && divisor_select && (addr == OFS_DATA || addr == OFS_IER);
  assign rd_buf = rd_en && addr == OFS_DATA && !divisor_select;
  assign rd_iir = rd_en && addr == OFS_IIR;
  assign rd_lsr = rd_en && addr == OFS_LSR;
  assign rd_msr = rd_en && addr == OFS_MSR;

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divisor_low_q <= RST_DIV[7:0];
      divisor_high_q <= RST_DIV[15:8];
      irq_enable_q <= '0;
      line_control_q <= RST_REG;
      modem_control_q <= '0;
      scratch_q <= RST_REG;
    end else if (wr_en) begin
      unique case (addr)
        OFS_DATA: if (divisor_select) divisor_low_q <= wdata;
        OFS_IER: begin
          if (divisor_select) divisor_high_q <= wdata;
          else irq_enable_q <= wdata[3:0]; // see RULE6
        end
        OFS_LCR: line_control_q <= wdata;
        OFS_MCR: modem_control_q <= wdata[4:0];
        OFS_SCR: scratch_q <= wdata;
        default: ;
      endcase
    end
  end

  assign divisor = {divisor_high_q, divisor_low_q}; // see RULE19
  assign modem_ctrl = modem_control_q;

  // reload the baud counter once the new latch value stands
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_load_q <= 1'b0;
    end else begin
      div_load_q <= wr_div; // see RULE19
    end
  end

  // ------------------------------------------------------------
  // transmit holding register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_holding_q <= RST_REG;
      hold_full_q <= 1'b0;
    end else if (wr_data) begin
      tx_holding_q <= wdata;
      hold_full_q <= 1'b1; // see RULE10
    end else if (tx_take) begin
      hold_full_q <= 1'b0; // see RULE11
    end
  end

  assign tx_holding_empty = !hold_full_q; // see RULE9 RULE13
  assign tx_all_empty = !hold_full_q && !tx_busy; // see RULE12 RULE14

  // ------------------------------------------------------------
  // receive buffer and line status flags, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_buffer_q <= RST_REG;
      rx_ready_q <= 1'b0;
      overrun_q <= 1'b0;
      parity_err_q <= 1'b0;
      framing_err_q <= 1'b0;
      break_seen_q <= 1'b0;
    end else begin
      if (rx_load) rx_buffer_q <= rx_data; // see RULE16
      rx_ready_q <= rx_load || (rx_ready_q && !rd_buf);
      overrun_q <= (rx_load && rx_ready_q && !rd_buf) || (overrun_q && !rd_lsr);
      parity_err_q <= rx_parity_err || (parity_err_q && !rd_lsr);
      framing_err_q <= rx_framing_err || (framing_err_q && !rd_lsr);
      break_seen_q <= rx_break || (break_seen_q && !rd_lsr);
    end
  end

  // ------------------------------------------------------------
  // modem lines: two-stage sync, then delta detection
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msync1_q <= '0;
      msync2_q <= '0;
      mprev_q <= '0;
    end else begin
      msync1_q <= modem_in;
      msync2_q <= msync1_q;
      mprev_q <= msync2_q;
    end
  end

  assign mset = {msync2_q[3] ^ mprev_q[3], !msync2_q[2] && mprev_q[2],
                 msync2_q[1] ^ mprev_q[1], msync2_q[0] ^ mprev_q[0]};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mdelta_q <= '0;
    end else begin
      mdelta_q <= mset | (mdelta_q & {4{!rd_msr}}); // see RULE8
    end
  end

  // ------------------------------------------------------------
  // holding empty interrupt flag
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_holding_empty_prev_q <= 1'b1;
      tx_irq_q <= 1'b1;
    end else begin
      tx_holding_empty_prev_q <= tx_holding_empty;
      if (tx_holding_empty && !tx_holding_empty_prev_q) tx_irq_q <= 1'b1;
      else if (wr_data || (rd_iir && ident == ID_TX)) tx_irq_q <= 1'b0; // see RULE18
    end
  end

  // ------------------------------------------------------------
  // interrupt priority and identification
  // ------------------------------------------------------------
  assign src_line = irq_enable_q[2] &&
                    (overrun_q || parity_err_q || framing_err_q || break_seen_q); // see RULE5
  assign src_rx = irq_enable_q[0] && rx_ready_q; // see RULE4
  assign src_tx = irq_enable_q[1] && tx_irq_q; // see RULE4
  assign src_modem = irq_enable_q[3] && (|mdelta_q); // see RULE5

  always_comb begin
    if (src_line) ident = ID_LINE; // see RULE17
    else if (src_rx) ident = ID_RX;
    else if (src_tx) ident = ID_TX;
    else if (src_modem) ident = ID_MODEM;
    else ident = ID_NONE; // see RULE1 RULE2
  end

  assign irq_ident = {5'h00, ident}; // see RULE3
  assign irq_out = src_line || src_rx || src_tx || src_modem; // see RULE7 RULE8
  assign line_status = {1'b0, tx_all_empty, tx_holding_empty, break_seen_q,
                        framing_err_q, parity_err_q, overrun_q, rx_ready_q};
  assign modem_status = {msync2_q, mdelta_q};

  // ------------------------------------------------------------
  // read data, registered
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata <= RST_REG;
    end else if (rd_en) begin
      unique case (addr)
        OFS_DATA: rdata <= divisor_select ? divisor_low_q : rx_buffer_q;
        OFS_IER: rdata <= divisor_select ? divisor_high_q : {4'h0, irq_enable_q};
        OFS_IIR: rdata <= irq_ident;
        OFS_LCR: rdata <= line_control_q;
        OFS_MCR: rdata <= {3'h0, modem_control_q};
        OFS_LSR: rdata <= line_status;
        OFS_MSR: rdata <= modem_status;
        OFS_SCR: rdata <= scratch_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // baud divider and shifter
  // ------------------------------------------------------------
  ucr_baud #(
    .DW(16)
  ) u_baud (
    .clk_sys(clk_sys),
    .rst(rst),
    .divisor(divisor),
    .reload(div_load_q),
    .tick16(tick16)
  );

  ucr_tx u_tx (
    .clk_sys(clk_sys),
    .rst(rst),
    .tick16(tick16),
    .hold_full(hold_full_q),
    .hold_data(tx_holding_q),
    .line_control(line_control_q),
    .take(tx_take),
    .busy(tx_busy),
    .serial_out(serial_out)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_ident_none: assert property (!irq_out |-> irq_ident == 8'h01) // see RULE1
    else $error("ident shows pending with no interrupt");
  chk_ident_upper: assert property (rd_iir |=> rdata[7:3] == 5'h00) // see RULE3
    else $error("ident upper bits not zero");
  chk_line_first: assert property (src_line |-> ident == ID_LINE && irq_out) // see RULE17
    else $error("line status not reported first");
  chk_rx_gate: assert property (rx_ready_q && !irq_enable_q[0] && !src_line // see RULE4
                                |-> ident != ID_RX)
    else $error("disabled receive interrupt reported");
  chk_all_masked: assert property (irq_enable_q == 4'h0 // see RULE8
                                   |-> !irq_out && ident == ID_NONE)
    else $error("interrupt with all enables clear");
  chk_ier_upper: assert property (rd_en && addr == OFS_IER && !divisor_select // see RULE6
                                  |=> rdata[7:4] == 4'h0)
    else $error("enable upper bits not zero");
  chk_write_tx_holding_empty: assert property (wr_data |=> !tx_holding_empty) // see RULE10
    else $error("holding empty after write");
  chk_take_tx_holding_empty: assert property (tx_take && !wr_data // see RULE11
                                  |=> tx_holding_empty && !tx_all_empty)
    else $error("holding empty not set at transfer");
  chk_busy_tx_all_empty: assert property (tx_busy |-> !tx_all_empty) // see RULE12
    else $error("all empty while shifting");
  chk_hold_wait: assert property (hold_full_q && tx_busy |=> hold_full_q) // see RULE13
    else $error("holding lost while shifter busy");
  chk_tx_holding_empty_clear: assert property (rd_iir && ident == ID_TX // see RULE18
                                   && !(tx_holding_empty && !tx_holding_empty_prev_q) |=> !tx_irq_q)
    else $error("holding empty interrupt not cleared");
  chk_divisor: assert property (wr_en && addr == OFS_IER && divisor_select // see RULE19
                                |=> divisor[15:8] == $past(wdata))
    else $error("high latch not in divisor");

  cov_tx_frame: cover property (tx_take ##[1:1000] !tx_busy);
  cov_back_to_back: cover property (wr_data ##[1:50] tx_busy && hold_full_q);
  cov_tx_irq: cover property (src_tx && ident == ID_TX ##1 !tx_irq_q);
  cov_modem_irq: cover property (src_modem && ident == ID_MODEM);
endmodule // ucr_channel

// ==== tb/ucr_line_rx.sv ====
/*
  serial line receiver model standing on the far side of serial_out.
  assumes divisor 1, so one bit lasts BIT clk_sys cycles; cfg mirrors line_control.
*/
`timescale 1ns/10ps
module ucr_line_rx #(
  parameter int BIT = 16
) (
  input wire logic clk_sys,
  input wire logic line,
  input wire logic [7:0] cfg,
  output logic [7:0] data,
  output logic par,
  output logic ok,
  output int count
);
  int i;
  // ------------------------------------------------------------
  // frame capture
  // ------------------------------------------------------------
  initial begin
    count = 0;
    data = 8'h00;
    par = 1'b0;
    ok = 1'b0;
    forever begin
      @(negedge line);
      repeat (BIT / 2) @(posedge clk_sys);
      ok = (line === 1'b0);
      data = 8'h00;
      for (i = 0; i < 5 + cfg[1:0]; i++) begin
        repeat (BIT) @(posedge clk_sys);
        data[i] = line;
      end
      if (cfg[3]) begin
        repeat (BIT) @(posedge clk_sys);
        par = line;
      end
      for (i = 0; i <= cfg[2]; i++) begin
        repeat (BIT) @(posedge clk_sys);
        ok = ok & (line === 1'b1);
      end
      count++;
    end
  end
endmodule // ucr_line_rx

// ==== tb/ucr_channel_tb_top.sv ====
/*
  self-checking bench for one serial channel: registers, interrupts, transmit path.
  assumes host strobes on clk_sys and the line model on serial_out.
*/
`timescale 1ns/10ps
module ucr_channel_tb_top;
  import ucr_pkg::*;
  logic clk_sys, rst, wr_en, rd_en, rx_load, rx_parity_err, irq_out, tick16, serial_out;
  logic rx_framing_err, rx_break;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rx_data, v, b, b2, lcr_v, mask;
  logic [3:0] modem_in;
  logic [4:0] modem_ctrl;
  logic [15:0] divisor;
  logic [7:0] m_data;
  logic m_par, m_ok;
  int m_count, n_mismatch, total_checks, cyc, seed, k, t;
  ucr_channel dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .rdata(rdata), .rx_load(rx_load), .rx_data(rx_data),
    .rx_parity_err(rx_parity_err), .rx_framing_err(rx_framing_err), .rx_break(rx_break),
    .modem_in(modem_in), .modem_ctrl(modem_ctrl), .divisor(divisor), .tick16(tick16),
    .serial_out(serial_out), .irq_out(irq_out));
  ucr_line_rx #(.BIT(16)) line_u (.clk_sys(clk_sys), .line(serial_out), .cfg(lcr_v),
    .data(m_data), .par(m_par), .ok(m_ok), .count(m_count));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk_sys);
    #1 wr_en = 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1 addr = a;
    rd_en = 1'b1;
    @(posedge clk_sys);
    #1 rd_en = 1'b0;
    d = rdata;
  endtask
  task automatic rchk(input string n, input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(n, e, d);
  endtask
  task automatic irq_chk(input logic e);
    @(posedge clk_sys);
    #1 chk1("irq_out", e, irq_out);
  endtask
  function automatic logic [7:0] exp_iir(input logic [3:0] en, input logic ln, input logic rx,
                                         input logic tx, input logic md);
    if (en[2] && ln) return {5'h00, ID_LINE};
    if (en[0] && rx) return {5'h00, ID_RX};
    if (en[1] && tx) return {5'h00, ID_TX};
    if (en[3] && md) return {5'h00, ID_MODEM};
    return {5'h00, ID_NONE};
  endfunction
  function automatic logic exp_par(input logic [7:0] d, input logic even, input logic stick);
    if (stick) return !even;
    return even ? ^d : ~^d;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // clock, timeout
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 46738;
    cyc = 0;
    n_mismatch = 0;
    total_checks = 0;
    rst = 1'b1;
    {wr_en, rd_en, rx_load, rx_parity_err, rx_framing_err, rx_break} = 6'h00;
    addr = 3'h0;
    wdata = 8'h00;
    rx_data = 8'h00;
    modem_in = 4'h0;
    lcr_v = 8'h03;
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    rchk("lsr", OFS_LSR, 8'h60);
    wr(OFS_IIR, 8'hFF);
    rchk("iir", OFS_IIR, 8'h01);
    chk1("irq_out", 1'b0, irq_out);
    b = 8'($random(seed));
    wr(OFS_SCR, b);
    rchk("scratch", OFS_SCR, b);
    wr(OFS_MCR, b);
    rchk("mcr", OFS_MCR, b & 8'h1F);
    chk8("modem_ctrl", b & 8'h1F, {3'h0, modem_ctrl});
    $display("test reset done");
    wr(OFS_IER, 8'hFF);
    rchk("ier", OFS_IER, 8'h0F);
    irq_chk(1'b1);
    rchk("iir", OFS_IIR, exp_iir(4'hF, 0, 0, 1, 0));
    rchk("iir", OFS_IIR, 8'h01);
    irq_chk(1'b0);
    b = 8'($random(seed));
    @(posedge clk_sys);
    #1 rx_load = 1'b1;
    rx_data = b;
    @(posedge clk_sys);
    #1 rx_load = 1'b0;
    rchk("iir", OFS_IIR, exp_iir(4'hF, 0, 1, 0, 0));
    {rx_parity_err, rx_framing_err, rx_break} = 3'h7;
    @(posedge clk_sys);
    #1 {rx_parity_err, rx_framing_err, rx_break} = 3'h0;
    rchk("iir", OFS_IIR, exp_iir(4'hF, 1, 1, 0, 0));
    rchk("lsr", OFS_LSR, 8'h7D);
    rchk("iir", OFS_IIR, exp_iir(4'hF, 0, 1, 0, 0));
    rchk("rx_buffer", OFS_DATA, b);
    modem_in = 4'h1;
    repeat (4) @(posedge clk_sys);
    rchk("iir", OFS_IIR, exp_iir(4'hF, 0, 0, 0, 1));
    rchk("msr", OFS_MSR, 8'h11);
    rchk("iir", OFS_IIR, 8'h01);
    $display("test priority done");
    wr(OFS_IER, 8'h00);
    @(posedge clk_sys);
    #1 rx_load = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 rx_load = 1'b0;
    modem_in = 4'h3;
    repeat (4) @(posedge clk_sys);
    chk1("irq_out", 1'b0, irq_out);
    rchk("iir", OFS_IIR, 8'h01);
    rchk("lsr", OFS_LSR, 8'h63);
    rchk("msr", OFS_MSR, 8'h32);
    rd(OFS_DATA, v);
    $display("test masked done");
    wr(OFS_LCR, 8'h80);
    b = 8'($random(seed));
    b2 = 8'($random(seed));
    wr(OFS_DATA, b);
    wr(OFS_IER, b2);
    chk8("divisor_low", b, divisor[7:0]);
    chk8("divisor_high", b2, divisor[15:8]);
    rchk("divisor_high", OFS_IER, b2);
    wr(OFS_DATA, 8'h01);
    wr(OFS_IER, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1 chk1("tick16", 1'b1, tick16);
    $display("test divisor done");
    for (k = 0; k < 4; k++) begin
      lcr_v = (8'($random(seed)) & 8'h3C) | 8'(k);
      mask = 8'hFF >> (3 - k);
      wr(OFS_LCR, lcr_v);
      wr(OFS_IER, 8'h02);
      b = 8'($random(seed));
      b2 = 8'($random(seed));
      wr(OFS_DATA, b);
      repeat (6) @(posedge clk_sys);
      rchk("lsr", OFS_LSR, 8'h20);
      chk1("irq_out", 1'b1, irq_out);
      wr(OFS_DATA, b2);
      irq_chk(1'b0);
      rchk("lsr", OFS_LSR, 8'h00);
      for (t = 0; t < 2; t++) begin
        while (m_count < 2 * k + t + 1 && cyc < 19000) @(posedge clk_sys);
        v = (t == 0 ? b : b2) & mask;
        chk8("frame_data", v, m_data);
        chk1("frame_ok", 1'b1, m_ok);
        if (lcr_v[3]) begin
          chk1("frame_par", exp_par(v, lcr_v[4], lcr_v[5]), m_par);
        end
      end
      v = 8'h00;
      for (t = 0; t < 100 && v[6] !== 1'b1; t++) rd(OFS_LSR, v);
      chk8("lsr", 8'h60, v);
      rchk("iir", OFS_IIR, 8'h02);
      $display("test transmit %0d done", k);
    end
    final_report();
  end
endmodule // ucr_channel_tb_top
